// *** hw/tcc_defs.svh ***
// register offsets, field positions, reset values and counts of the timer
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH

`define TCC_OFF_CTRL_A   4'h0
`define TCC_OFF_CTRL_B   4'h1
`define TCC_OFF_CNT      4'h2
`define TCC_OFF_CMP_A    4'h3
`define TCC_OFF_CMP_B    4'h4
`define TCC_OFF_FLAG     4'h5
`define TCC_OFF_MASK     4'h6
`define TCC_OFF_POWER    4'h7

// timer_control_a fields
`define TCC_ACT_A_HI     7
`define TCC_ACT_A_LO     6
`define TCC_ACT_B_HI     5
`define TCC_ACT_B_LO     4
`define TCC_WGM_LO_HI    1
`define TCC_WGM_LO_LO    0
// timer_control_b fields
`define TCC_FOC_A_BIT    7
`define TCC_FOC_B_BIT    6
`define TCC_WGM2_BIT     3
`define TCC_CS_HI        2
`define TCC_CS_LO        0
// flag, mask and power fields
`define TCC_FLAG_B_BIT   2
`define TCC_FLAG_A_BIT   1
`define TCC_FLAG_OV_BIT  0
`define TCC_POWER_BIT    0

`define TCC_CTRL_RST     8'h00
`define TCC_CNT_RST      8'h00
`define TCC_CMP_RST      8'h00
`define TCC_FLAG_RST     3'h0
`define TCC_BOTTOM       8'h00
`define TCC_MAX          8'hFF

`define TCC_CS_STOP      3'h0
`define TCC_CS_DIV1      3'h1
`define TCC_CS_DIV8      3'h2
`define TCC_CS_DIV64     3'h3
`define TCC_CS_DIV256    3'h4
`define TCC_CS_DIV1024   3'h5
`define TCC_CS_EXT_FALL  3'h6
`define TCC_CS_EXT_RISE  3'h7

`define TCC_PSC_W        10
`define TCC_DIV8_MASK    10'h007
`define TCC_DIV64_MASK   10'h03F
`define TCC_DIV256_MASK  10'h0FF
`define TCC_DIV1024_MASK 10'h3FF

`define TCC_ACT_NONE     2'h0
`define TCC_ACT_TOGGLE   2'h1
`define TCC_ACT_CLEAR    2'h2
`define TCC_ACT_SET      2'h3

`endif

// *** hw/tcc_pkg.sv ***
// types shared by the timer/counter modules
`include "tcc_defs.svh"
package tcc_pkg;

    typedef enum logic [1:0] {
        TCC_DIR_UP   = 2'b01,
        TCC_DIR_DOWN = 2'b10
    } tcc_dir_e;

    typedef struct packed {
        logic [7:0]            cnt;
        tcc_dir_e              dir;
        logic [7:0]            cmp_a;
        logic [7:0]            cmp_b;
        logic [7:0]            buf_a;
        logic [7:0]            buf_b;
        logic [1:0]            act_a;
        logic [1:0]            act_b;
        logic [2:0]            wgm;
        logic [2:0]            cs;
        logic [2:0]            flags;
        logic [2:0]            mask;
        logic                  gate;
        logic                  blk;
        logic                  oc_a;
        logic                  oc_b;
        logic [`TCC_PSC_W-1:0] psc;
        logic [7:0]            rdata;
        logic [2:0]            irq;
    } tcc_state_s;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
        logic rise;
        logic fall;
    } tcc_sync_s;

endpackage : tcc_pkg

// *** hw/tcc_sync.sv ***
// three-stage pin synchroniser with edge pulses
`timescale 1ns/1ps
module tcc_sync
    import tcc_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    input  wire logic clk_en,
    input  wire logic pin_in,
    output logic      level,
    output logic      rise,
    output logic      fall
);

    tcc_sync_s st_r;
    tcc_sync_s st_nxt;

    always_comb
    begin
        st_nxt      = st_r;
        st_nxt.s1   = pin_in;
        st_nxt.s2   = st_r.s1;
        st_nxt.s3   = st_r.s2;
        // accept a change only once stages two and three agree
        if (st_r.s2 == st_r.s3)
        begin
            st_nxt.lvl = st_r.s3;
        end
        st_nxt.rise = st_nxt.lvl & ~st_r.lvl;
        st_nxt.fall = ~st_nxt.lvl & st_r.lvl;
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_r <= '0;
        end
        else if (clk_en)
        begin
            st_r <= st_nxt;
        end
    end

    assign level = st_r.lvl;
    assign rise  = st_r.rise;
    assign fall  = st_r.fall;

endmodule : tcc_sync

// *** hw/tcc_timer.sv ***
// 8-bit timer/counter with two compare units and register port
// What this block does
// - 0x00 is bottom, 0xFF is maximum
// - top is 0xFF or compare A
// - tick from prescaler or external pin edge
// - clock select zero stops all ticks
// - counter readable and writable at any time
// - software counter write beats count or clear
// - each tick clears, increments or decrements counter
// - mode bits split over control A and B
// - overflow flag point depends on mode
// - counter compared continuously with both compares
// - match sets compare flag at next tick
// - flag cleared by service or written one
// - three flags in one register, each masked
// - compares double buffered only in PWM modes
// - buffered compare loads at top or bottom
// - software reaches buffer or active compare
// - force strobe makes match in non-PWM modes
// - forced match: no flag, no counter change
// - counter write blocks matches next tick
// - output states kept across mode changes
// - output action field acts at once
// - reset clears output compare states
`timescale 1ns/1ps
`include "tcc_defs.svh"
module tcc_timer
    import tcc_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    input  wire logic       clk_en,
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       external_count_pin,
    input  wire logic       ack_overflow,
    input  wire logic       ack_match_a,
    input  wire logic       ack_match_b,
    output logic            irq_overflow,
    output logic            irq_match_a,
    output logic            irq_match_b,
    output logic            compare_output_a,
    output logic            compare_output_b
);

    tcc_state_s st_r;
    tcc_state_s st_nxt;

    logic       ext_rise;
    logic       ext_fall;
    logic       timer_tick;
    logic       pwm_mode;
    logic       fast_mode;
    logic       phase_mode;
    logic       ctc_mode;
    logic [7:0] top_val;
    logic       match_a;
    logic       match_b;
    logic       hit_a;
    logic       hit_b;
    logic       wr_cnt;
    logic       force_a;
    logic       force_b;
    logic [2:0] flag_clr;

    tcc_sync u_pin_sync (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .clk_en  (clk_en),
        .pin_in  (external_count_pin),
        .level   (),
        .rise    (ext_rise),
        .fall    (ext_fall)
    );

    // mode decode
    // every PWM mode has the low mode bit set
    assign pwm_mode   = st_r.wgm[0];
    assign fast_mode  = (st_r.wgm[1:0] == 2'b11);
    assign phase_mode = (st_r.wgm[1:0] == 2'b01);
    assign ctc_mode   = (st_r.wgm[1:0] == 2'b10);

    assign top_val = (st_r.wgm[2] || ctc_mode) ? st_r.cmp_a : `TCC_MAX;

    // tick source
    // the power gate also holds the tick low
    always_comb
    begin
        timer_tick = 1'b0;
        if (!st_r.gate)
        begin
            case (st_r.cs)
                `TCC_CS_STOP:     timer_tick = 1'b0;
                `TCC_CS_DIV1:     timer_tick = 1'b1;
                `TCC_CS_DIV8:     timer_tick =
                    ((st_r.psc & `TCC_DIV8_MASK) == `TCC_DIV8_MASK);
                `TCC_CS_DIV64:    timer_tick =
                    ((st_r.psc & `TCC_DIV64_MASK) == `TCC_DIV64_MASK);
                `TCC_CS_DIV256:   timer_tick =
                    ((st_r.psc & `TCC_DIV256_MASK) == `TCC_DIV256_MASK);
                `TCC_CS_DIV1024:  timer_tick =
                    ((st_r.psc & `TCC_DIV1024_MASK) == `TCC_DIV1024_MASK);
                `TCC_CS_EXT_FALL: timer_tick = ext_fall;
                default:          timer_tick = ext_rise;
            endcase
        end
    end

    assign match_a = (st_r.cnt == st_r.cmp_a);
    assign match_b = (st_r.cnt == st_r.cmp_b);
    // counter write masks matches at the next tick
    assign hit_a   = timer_tick && match_a && !st_r.blk;
    assign hit_b   = timer_tick && match_b && !st_r.blk;

    assign wr_cnt  = reg_wr && (reg_addr == `TCC_OFF_CNT);
    assign force_a = reg_wr && (reg_addr == `TCC_OFF_CTRL_B) &&
                     reg_wdata[`TCC_FOC_A_BIT] && !pwm_mode;
    assign force_b = reg_wr && (reg_addr == `TCC_OFF_CTRL_B) &&
                     reg_wdata[`TCC_FOC_B_BIT] && !pwm_mode;

    // clear by written one or by service
    assign flag_clr = ({3{reg_wr && (reg_addr == `TCC_OFF_FLAG)}} &
                       reg_wdata[2:0]) |
                      {ack_match_b, ack_match_a, ack_overflow};

    // output state on a match, per mode and action field
    function automatic logic oc_match(
        input logic [1:0] act,
        input logic       oc,
        input logic       pwm,
        input logic       down
    );
        logic v;
        v = oc;
        if (!pwm)
        begin
            case (act)
                `TCC_ACT_TOGGLE: v = ~oc;
                `TCC_ACT_CLEAR:  v = 1'b0;
                `TCC_ACT_SET:    v = 1'b1;
                default:         v = oc;
            endcase
        end
        else if (act == `TCC_ACT_CLEAR)
        begin
            v = down;
        end
        else if (act == `TCC_ACT_SET)
        begin
            v = ~down;
        end
        return v;
    endfunction : oc_match

    // fast PWM restarts the pulse at bottom
    function automatic logic oc_bottom(
        input logic [1:0] act,
        input logic       oc
    );
        logic v;
        v = oc;
        if (act == `TCC_ACT_CLEAR)
        begin
            v = 1'b1;
        end
        else if (act == `TCC_ACT_SET)
        begin
            v = 1'b0;
        end
        return v;
    endfunction : oc_bottom

    always_comb
    begin
        st_nxt       = st_r;
        st_nxt.psc   = st_r.gate ? st_r.psc :
                       st_r.psc + `TCC_PSC_W'(1);
        st_nxt.rdata = 8'h00;
        if (timer_tick)
        begin
            st_nxt.blk = 1'b0;
            if (phase_mode)
            begin
                case (st_r.dir)
                    TCC_DIR_UP:
                    begin
                        if (st_r.cnt == top_val)
                        begin
                            st_nxt.dir = TCC_DIR_DOWN;
                            st_nxt.cnt = st_r.cnt - 8'h01;
                            st_nxt.cmp_a = st_r.buf_a;
                            st_nxt.cmp_b = st_r.buf_b;
                        end
                        else
                        begin
                            st_nxt.cnt = st_r.cnt + 8'h01;
                        end
                    end
                    default:
                    begin
                        if (st_r.cnt == `TCC_BOTTOM)
                        begin
                            st_nxt.dir = TCC_DIR_UP;
                            st_nxt.cnt = st_r.cnt + 8'h01;
                            st_nxt.flags[`TCC_FLAG_OV_BIT] = 1'b1;
                        end
                        else
                        begin
                            st_nxt.cnt = st_r.cnt - 8'h01;
                        end
                    end
                endcase
            end
            else if (fast_mode)
            begin
                st_nxt.dir = TCC_DIR_UP;
                if (st_r.cnt == top_val)
                begin
                    st_nxt.cnt = `TCC_BOTTOM;
                    st_nxt.flags[`TCC_FLAG_OV_BIT] = 1'b1;
                    // load as the count returns to bottom
                    st_nxt.cmp_a = st_r.buf_a;
                    st_nxt.cmp_b = st_r.buf_b;
                    st_nxt.oc_a  = oc_bottom(st_r.act_a, st_r.oc_a);
                    st_nxt.oc_b  = oc_bottom(st_r.act_b, st_r.oc_b);
                end
                else
                begin
                    st_nxt.cnt = st_r.cnt + 8'h01;
                end
            end
            else
            begin
                st_nxt.dir = TCC_DIR_UP;
                if (ctc_mode && match_a)
                begin
                    st_nxt.cnt = `TCC_BOTTOM;
                end
                else
                begin
                    st_nxt.cnt = st_r.cnt + 8'h01;
                end
                if (st_r.cnt == `TCC_MAX)
                begin
                    st_nxt.flags[`TCC_FLAG_OV_BIT] = 1'b1;
                end
            end
            // action field used live, never buffered
            if (hit_a)
            begin
                st_nxt.oc_a = oc_match(st_r.act_a, st_r.oc_a, pwm_mode,
                                       st_r.dir == TCC_DIR_DOWN);
            end
            if (hit_b)
            begin
                st_nxt.oc_b = oc_match(st_r.act_b, st_r.oc_b, pwm_mode,
                                       st_r.dir == TCC_DIR_DOWN);
            end
        end
        // overflow and match flags; set beats any clear below
        st_nxt.flags = st_nxt.flags & ~flag_clr;
        st_nxt.flags[`TCC_FLAG_OV_BIT] = st_nxt.flags[`TCC_FLAG_OV_BIT] |
            (timer_tick && !phase_mode && !fast_mode &&
             st_r.cnt == `TCC_MAX) |
            (timer_tick && fast_mode && st_r.cnt == top_val) |
            (timer_tick && phase_mode && st_r.dir == TCC_DIR_DOWN &&
             st_r.cnt == `TCC_BOTTOM);
        st_nxt.flags[`TCC_FLAG_A_BIT] = st_nxt.flags[`TCC_FLAG_A_BIT] |
            hit_a;
        st_nxt.flags[`TCC_FLAG_B_BIT] = st_nxt.flags[`TCC_FLAG_B_BIT] |
            hit_b;
        // forced match touches only the output state
        if (force_a)
        begin
            st_nxt.oc_a = oc_match(st_r.act_a, st_r.oc_a, 1'b0, 1'b0);
        end
        if (force_b)
        begin
            st_nxt.oc_b = oc_match(st_r.act_b, st_r.oc_b, 1'b0, 1'b0);
        end
        // register writes; mode writes leave oc_a/oc_b alone
        if (reg_wr)
        begin
            if (reg_addr == `TCC_OFF_CTRL_A)
            begin
                st_nxt.act_a = reg_wdata[`TCC_ACT_A_HI:`TCC_ACT_A_LO];
                st_nxt.act_b = reg_wdata[`TCC_ACT_B_HI:`TCC_ACT_B_LO];
                st_nxt.wgm[1:0] =
                    reg_wdata[`TCC_WGM_LO_HI:`TCC_WGM_LO_LO];
            end
            else if (reg_addr == `TCC_OFF_CTRL_B)
            begin
                st_nxt.wgm[2] = reg_wdata[`TCC_WGM2_BIT];
                st_nxt.cs     = reg_wdata[`TCC_CS_HI:`TCC_CS_LO];
            end
            else if (wr_cnt)
            begin
                // software write wins over the count
                st_nxt.cnt = reg_wdata;
                st_nxt.blk = 1'b1;
            end
            else if (reg_addr == `TCC_OFF_CMP_A)
            begin
                st_nxt.buf_a = reg_wdata;
                if (!pwm_mode)
                begin
                    st_nxt.cmp_a = reg_wdata;
                end
            end
            else if (reg_addr == `TCC_OFF_CMP_B)
            begin
                st_nxt.buf_b = reg_wdata;
                if (!pwm_mode)
                begin
                    st_nxt.cmp_b = reg_wdata;
                end
            end
            else if (reg_addr == `TCC_OFF_MASK)
            begin
                st_nxt.mask = reg_wdata[2:0];
            end
            else if (reg_addr == `TCC_OFF_POWER)
            begin
                st_nxt.gate = reg_wdata[`TCC_POWER_BIT];
            end
        end
        // read path; force strobes always read as zero
        if (reg_rd)
        begin
            if (reg_addr == `TCC_OFF_CTRL_A)
            begin
                st_nxt.rdata = {st_r.act_a, st_r.act_b, 2'b00,
                                st_r.wgm[1:0]};
            end
            else if (reg_addr == `TCC_OFF_CTRL_B)
            begin
                st_nxt.rdata = {4'h0, st_r.wgm[2], st_r.cs};
            end
            else if (reg_addr == `TCC_OFF_CNT)
            begin
                st_nxt.rdata = st_r.cnt;
            end
            else if (reg_addr == `TCC_OFF_CMP_A)
            begin
                st_nxt.rdata = st_r.buf_a;
            end
            else if (reg_addr == `TCC_OFF_CMP_B)
            begin
                st_nxt.rdata = st_r.buf_b;
            end
            else if (reg_addr == `TCC_OFF_FLAG)
            begin
                st_nxt.rdata = {5'h00, st_r.flags};
            end
            else if (reg_addr == `TCC_OFF_MASK)
            begin
                st_nxt.rdata = {5'h00, st_r.mask};
            end
            else if (reg_addr == `TCC_OFF_POWER)
            begin
                st_nxt.rdata = {7'h00, st_r.gate};
            end
            else
            begin
                st_nxt.rdata = 8'h00;
            end
        end
        st_nxt.irq = st_nxt.flags & st_nxt.mask;
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_r       <= '0;
            st_r.dir   <= TCC_DIR_UP;
        end
        else if (clk_en)
        begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata        = st_r.rdata;
    assign irq_overflow     = st_r.irq[`TCC_FLAG_OV_BIT];
    assign irq_match_a      = st_r.irq[`TCC_FLAG_A_BIT];
    assign irq_match_b      = st_r.irq[`TCC_FLAG_B_BIT];
    assign compare_output_a = st_r.oc_a;
    assign compare_output_b = st_r.oc_b;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    stop_no_tick_a: assert property (
        (st_r.cs == `TCC_CS_STOP) |-> !timer_tick)
        else $error("tick while clock select is zero");

    write_wins_a: assert property (
        (clk_en && wr_cnt) |=> (st_r.cnt == $past(reg_wdata)))
        else $error("counter write lost");

    match_sets_a: assert property (
        (clk_en && timer_tick && match_a && !st_r.blk)
            |=> st_r.flags[`TCC_FLAG_A_BIT])
        else $error("match A did not set its flag");

    write_blocks_a: assert property (
        (clk_en && wr_cnt) ##1 (clk_en && timer_tick && !reg_wr)
            |=> !$rose(st_r.flags[`TCC_FLAG_A_BIT]) &&
                !$rose(st_r.flags[`TCC_FLAG_B_BIT]))
        else $error("match not blocked after counter write");

    normal_wrap_a: assert property (
        (clk_en && timer_tick && st_r.wgm == 3'h0 && !reg_wr &&
         st_r.cnt == `TCC_MAX)
            |=> (st_r.cnt == `TCC_BOTTOM) &&
                st_r.flags[`TCC_FLAG_OV_BIT])
        else $error("normal mode wrap or overflow wrong");

    ctc_clear_a: assert property (
        (clk_en && timer_tick && st_r.wgm == 3'h2 && !reg_wr && match_a)
            |=> (st_r.cnt == `TCC_BOTTOM))
        else $error("clear on match A failed");

    force_no_flag_a: assert property (
        (clk_en && force_a && !timer_tick)
            |=> !$rose(st_r.flags[`TCC_FLAG_A_BIT]) &&
                $stable(st_r.cnt))
        else $error("forced match changed flag or counter");

    pwm_buffer_a: assert property (
        (clk_en && pwm_mode && !timer_tick && reg_wr &&
         reg_addr == `TCC_OFF_CMP_A)
            |=> $stable(st_r.cmp_a) && (st_r.buf_a == $past(reg_wdata)))
        else $error("PWM compare write reached active register");

    irq_gate_a: assert property (
        clk_en ##1 1'b1 |-> (st_r.irq == (st_r.flags & st_r.mask)))
        else $error("request not gated by mask");

    ack_clears_a: assert property (
        (clk_en && ack_match_a && !hit_a) |=>
            !st_r.flags[`TCC_FLAG_A_BIT])
        else $error("service did not clear match flag A");

    ovf_seen_c: cover property (
        clk_en && timer_tick && st_r.cnt == `TCC_MAX ##1
        st_r.flags[`TCC_FLAG_OV_BIT]);
    force_hit_c: cover property (clk_en && force_a);
    phase_turn_c: cover property (
        phase_mode && st_r.dir == TCC_DIR_UP ##1
        st_r.dir == TCC_DIR_DOWN);
    fast_load_c: cover property (
        clk_en && fast_mode && timer_tick && st_r.cnt == top_val);

endmodule : tcc_timer

// *** tb/tcc_tb_top.sv ***
// register-level testbench for the 8-bit timer/counter
`timescale 1ns/1ps
`include "tcc_defs.svh"
module tb_top;
    logic       ref_clk, sys_rst, clk_en, reg_wr, reg_rd, pin;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, v;
    logic       ack_ov, ack_a, ack_b, irq_ov, irq_a, irq_b, oc_a, oc_b;
    int         errors, comparisons;

    tcc_timer dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .external_count_pin(pin), .ack_overflow(ack_ov),
        .ack_match_a(ack_a), .ack_match_b(ack_b),
        .irq_overflow(irq_ov), .irq_match_a(irq_a),
        .irq_match_b(irq_b), .compare_output_a(oc_a),
        .compare_output_b(oc_b));

    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task final_report;
        $display("checks %0d mismatches %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report

    task chk8(input string name, input logic [7:0] exp, got);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH %s exp %h got %h", name, exp, got);
        end
    endtask : chk8

    task idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : idle

    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask : wr

    // read data stands only in the cycle after the strobe
    task rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd

    // watchdog: a hang ends the run as a failure
    initial
    begin
        #100000;
        errors++;
        final_report();
    end

    initial
    begin
        sys_rst = 1'b1; clk_en = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0;
        pin = 1'b0; reg_addr = 4'h0; reg_wdata = 8'h00;
        ack_ov = 1'b0; ack_a = 1'b0; ack_b = 1'b0;
        errors = 0; comparisons = 0;
        idle(4);
        sys_rst <= 1'b0;
        wr(`TCC_OFF_POWER, 8'h00);
        chk8("oc_a", 8'h00, {7'h00, oc_a});
        chk8("oc_b", 8'h00, {7'h00, oc_b});
        wr(`TCC_OFF_CNT, 8'hA5);
        idle(20);
        rd(`TCC_OFF_CNT, v);
        chk8("cnt_stopped", 8'hA5, v);
        $display("test reset_access done");
        // wrap sets overflow and both matches at 0x00
        wr(`TCC_OFF_CNT, 8'hFE);
        wr(`TCC_OFF_CTRL_B, {5'h00, `TCC_CS_DIV1});
        idle(4);
        wr(`TCC_OFF_CTRL_B, 8'h00);
        rd(`TCC_OFF_FLAG, v);
        chk8("flags_wrap", 8'h07, v);
        wr(`TCC_OFF_FLAG, 8'h07);
        rd(`TCC_OFF_FLAG, v);
        chk8("flags_clr", 8'h00, v);
        $display("test overflow done");
        // only unit A passes its compare
        wr(`TCC_OFF_CMP_A, 8'h40);
        wr(`TCC_OFF_CMP_B, 8'h80);
        wr(`TCC_OFF_MASK, 8'h02);
        wr(`TCC_OFF_CNT, 8'h3E);
        wr(`TCC_OFF_CTRL_B, {5'h00, `TCC_CS_DIV1});
        idle(4);
        wr(`TCC_OFF_CTRL_B, 8'h00);
        rd(`TCC_OFF_FLAG, v);
        chk8("flags_a", 8'h02, v);
        chk8("irq_mask", 8'h02, {5'h00, irq_b, irq_a, irq_ov});
        @(posedge ref_clk);
        ack_a <= 1'b1;
        @(posedge ref_clk);
        ack_a <= 1'b0;
        idle(2);
        chk8("irq_ack", 8'h00, {7'h00, irq_a});
        $display("test compare done");
        // counter write equal to compare blocks the next match
        wr(`TCC_OFF_CNT, 8'h40);
        wr(`TCC_OFF_CTRL_B, {5'h00, `TCC_CS_DIV1});
        idle(2);
        wr(`TCC_OFF_CTRL_B, 8'h00);
        rd(`TCC_OFF_FLAG, v);
        chk8("flags_block", 8'h00, v);
        $display("test block done");
        // forced match in normal mode: set, then toggle
        wr(`TCC_OFF_CNT, 8'h11);
        wr(`TCC_OFF_CTRL_A, 8'hC0);
        wr(`TCC_OFF_CTRL_B, 8'h80);
        idle(2);
        chk8("force_set", 8'h01, {7'h00, oc_a});
        rd(`TCC_OFF_FLAG, v);
        chk8("force_flag", 8'h00, v);
        rd(`TCC_OFF_CNT, v);
        chk8("force_cnt", 8'h11, v);
        wr(`TCC_OFF_CTRL_A, 8'h40);
        wr(`TCC_OFF_CTRL_B, 8'h80);
        idle(2);
        chk8("force_tgl", 8'h00, {7'h00, oc_a});
        // set unit B first so a wrongly taken toggle would show
        wr(`TCC_OFF_CTRL_A, 8'h30);
        wr(`TCC_OFF_CTRL_B, 8'h40);
        idle(2);
        chk8("force_set_b", 8'h01, {7'h00, oc_b});
        // mode change keeps state; force ignored in PWM
        wr(`TCC_OFF_CTRL_A, 8'h13);
        wr(`TCC_OFF_CTRL_B, 8'h40);
        idle(2);
        chk8("pwm_keep", 8'h01, {7'h00, oc_b});
        $display("test force done");
        final_report();
    end
endmodule : tb_top
